// ---- bench/pldc_board.sv ----
// Board model: active-low push buttons with pull-ups
`timescale 1ns/10ps
module pldc_board (
    input  wire logic       ref_clk,
    input  wire logic [3:0] press_req,
    input  wire logic [7:0] hold,
    output logic [3:0]      btn_b,
    output logic            busy
);
    logic [8:0] cnt_r;

    initial begin
        btn_b = 4'hF;
        busy  = 1'b0;
        cnt_r = 9'h000;
    end

    // Low for hold+1 cycles, then released high for hold-1 cycles
    always @(posedge ref_clk) begin
        if (!busy && press_req != 4'h0) begin
            cnt_r <= {hold, 1'b0};
            busy  <= 1'b1;
            btn_b <= ~press_req;
        end else if (busy) begin
            cnt_r <= cnt_r - 9'h001;
            if (cnt_r == {1'b0, hold}) begin
                btn_b <= 4'hF;
            end
            if (cnt_r == 9'h001) begin
                busy <= 1'b0;
            end
        end
    end
endmodule : pldc_board

// ---- bench/tb_power_load_demo_controller.sv ----
// Self-checking bench of the power load demo controller
`timescale 1ns/10ps
module tb_power_load_demo_controller;
    import pldc_pkg::*;
    logic                 ref_clk, rst_b, read, write, busy, led_out_en_r, load_sink_r;
    logic                 waitrequest;
    logic [3:0]           address, byteenable, btn_b, press_req;
    logic [7:0]           hold;
    logic [31:0]          writedata, readdata, q;
    logic [1:0]           led_freq_r;
    logic [4:0]           led_res_r;
    logic [PIN_COUNT-1:0] load_pins, a, b;
    int                   miscompares, checked, cur_f, cur_r;

    pldc_top #(.DEBOUNCE_CYCLES(20'h00004)) dut (
        .ref_clk(ref_clk), .rst_b(rst_b),
        .push_button_zero_b(btn_b[0]), .push_button_one_b(btn_b[1]),
        .push_button_two_b(btn_b[2]), .push_button_three_b(btn_b[3]),
        .address(address), .read(read), .write(write), .byteenable(byteenable),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .led_freq_r(led_freq_r), .led_res_r(led_res_r), .led_out_en_r(led_out_en_r),
        .load_sink_r(load_sink_r), .load_pins(load_pins));

    pldc_board board (.ref_clk(ref_clk), .press_req(press_req), .hold(hold),
        .btn_b(btn_b), .busy(busy));

    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [159:0] exp, input logic [159:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [3:0] ad, input logic [31:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= ad;
        writedata <= d;
        byteenable <= be;
        read <= !wr;
        write <= wr;
        @(posedge ref_clk);
        while (waitrequest !== 1'b0 && n < 50) begin
            @(posedge ref_clk);
            n++;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        chk("bus answer", 0, (n >= 50));
        if (n >= 50) begin
            stop_test();
        end
    endtask : bus

    task automatic ctrl(input int bitno);
        bus(1'b1, ADDR_CTRL, 32'h1 << bitno, 4'hF, q);
        repeat (3) @(posedge ref_clk);
    endtask : ctrl

    task automatic press(input int idx, input logic [7:0] h);
        int n;
        n = 0;
        @(posedge ref_clk);
        press_req <= 4'h1 << idx;
        hold <= h;
        @(posedge ref_clk);
        press_req <= 4'h0;
        @(posedge ref_clk);
        while (busy !== 1'b0 && n < 600) begin
            @(posedge ref_clk);
            n++;
        end
        chk("press done", 0, (n >= 600));
        if (n >= 600) begin
            stop_test();
        end
        repeat (3) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : press

    task automatic set_state(input int f, input int r);
        while (cur_f != f) begin
            ctrl(CTRL_FREQ_BIT);
            cur_f = (cur_f + 1) % 4;
        end
        while (cur_r != r) begin
            ctrl(CTRL_RES_BIT);
            cur_r = (cur_r + 1) % 20;
        end
        @(negedge ref_clk);
    endtask : set_state

    task automatic t_freq_buttons();
        for (int i = 1; i <= 4; i++) begin
            press(BTN_FREQ, 8'h0C);
            chk("led_freq", i % 4, led_freq_r);
        end
        press(BTN_FREQ, 8'h02);
        chk("led_freq glitch", 0, led_freq_r);
        press(BTN_FREQ, 8'h28);
        chk("led_freq held", 1, led_freq_r);
        cur_f = 1;
    endtask : t_freq_buttons

    task automatic t_res_bus();
        for (int i = 1; i <= 20; i++) begin
            ctrl(CTRL_RES_BIT);
            bus(1'b0, ADDR_STATUS, 32'h0, 4'hF, q);
            chk("led_res", i % 20, led_res_r);
            chk("status", {(i % 20), 2'(cur_f)}, q);
        end
        bus(1'b1, ADDR_CTRL, 32'h2, 4'h0, q);
        repeat (3) @(posedge ref_clk);
        chk("led_res no lane", 0, led_res_r);
        bus(1'b1, ADDR_STATUS, 32'hFF, 4'hF, q);
        bus(1'b0, ADDR_STATUS, 32'h0, 4'hF, q);
        chk("status ro", {5'h00, 2'(cur_f)}, q);
        bus(1'b0, ADDR_CTRL, 32'h0, 4'hF, q);
        chk("ctrl read", 0, q);
        bus(1'b0, 4'h8, 32'h0, 4'hF, q);
        chk("unmapped read", 0, q);
    endtask : t_res_bus

    task automatic t_pins();
        int c;
        int exp_c [4] = '{0, 2, 4, 6};
        int s;
        logic k;
        set_state(3, 2);
        chk("pins idle", 0, load_pins);
        press(BTN_TOGGLE, 8'h0C);
        chk("led_out_en on", 1, led_out_en_r);
        a = load_pins;
        @(negedge ref_clk);
        chk("pins mask 3 tiles", (160'h1 << 24) - 1, a ^ load_pins);
        s = 0;
        for (int f = 0; f < 4; f++) begin
            set_state(f, 2);
            c = 0;
            repeat (6) begin
                a = load_pins;
                k = load_sink_r;
                @(negedge ref_clk);
                c += (a[16] !== load_pins[16]);
                s += (k !== load_sink_r);
            end
            chk("toggle count", exp_c[f], c);
        end
        chk("load sink moving", 1, (s > 0));
        set_state(3, 19);
        a = load_pins;
        @(negedge ref_clk);
        b = ~160'h0;
        chk("pins mask all", b, a ^ load_pins);
        press(BTN_TOGGLE, 8'h0C);
        chk("led_out_en off", 0, led_out_en_r);
        chk("pins off", 0, load_pins);
    endtask : t_pins

    task automatic t_soft_reset();
        press(BTN_TOGGLE, 8'h0C);
        press(BTN_RESET, 8'h0C);
        chk("reset btn leds", 0, {led_out_en_r, led_res_r, led_freq_r});
        cur_f = 0;
        cur_r = 0;
        set_state(2, 5);
        press(BTN_TOGGLE, 8'h0C);
        chk("led_out_en pre", 1, led_out_en_r);
        ctrl(CTRL_RST_BIT);
        @(negedge ref_clk);
        chk("soft reset leds", 0, {led_out_en_r, led_res_r, led_freq_r});
        chk("soft reset pins", 0, load_pins);
    endtask : t_soft_reset

    initial begin
        ref_clk = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end

    initial begin
        #(CLK_PERIOD_NS * 40000);
        miscompares++;
        stop_test();
    end

    initial begin
        rst_b = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 4'h0;
        byteenable = 4'h0;
        writedata = 32'h0;
        press_req = 4'h0;
        hold = 8'h0C;
        miscompares = 0;
        checked = 0;
        cur_f = 0;
        cur_r = 0;
        repeat (16) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(negedge ref_clk);
        chk("reset leds", 0, {led_out_en_r, led_res_r, led_freq_r});
        chk("reset wait", 1, waitrequest);
        chk("reset pins", 0, load_pins);
        t_freq_buttons();
        t_res_bus();
        t_pins();
        t_soft_reset();
        stop_test();
    end
endmodule : tb_power_load_demo_controller

// ---- design/pldc_pkg.sv ----
// Shared constants and types of the power load demo controller
package pldc_pkg;

    localparam int unsigned CLK_MHZ         = 10;
    localparam int unsigned CLK_PERIOD_NS   = 100;
    localparam int unsigned DEBOUNCE_US     = 10000;
    localparam logic [19:0] DEBOUNCE_CYC    = 20'(DEBOUNCE_US * CLK_MHZ);

    localparam int unsigned TILE_COUNT      = 20;
    localparam int unsigned TILE_PINS       = 8;
    localparam int unsigned PIN_COUNT       = TILE_COUNT * TILE_PINS;
    localparam logic [4:0]  RES_LAST        = 5'h13;
    localparam logic [4:0]  RES_RESET       = 5'h00;
    localparam logic [1:0]  PHASE_MOD       = 2'h3;

    localparam logic [3:0]  ADDR_STATUS     = 4'h0;
    localparam logic [3:0]  ADDR_CTRL       = 4'h4;
    localparam int unsigned STAT_FREQ_LSB   = 0;
    localparam int unsigned STAT_RES_LSB    = 2;
    localparam int unsigned STAT_OUTEN_BIT  = 7;
    localparam int unsigned CTRL_FREQ_BIT   = 0;
    localparam int unsigned CTRL_RES_BIT    = 1;
    localparam int unsigned CTRL_TOG_BIT    = 2;
    localparam int unsigned CTRL_RST_BIT    = 3;

    localparam int unsigned BTN_RESET       = 0;
    localparam int unsigned BTN_FREQ        = 1;
    localparam int unsigned BTN_RES         = 2;
    localparam int unsigned BTN_TOGGLE      = 3;

    localparam logic [7:0]  LFSR_RESET      = 8'h01;
    localparam logic [7:0]  LFSR_TAPS       = 8'hB8;

    typedef enum logic [3:0] {
        PLDC_F_STOP = 4'h1,
        PLDC_F_33   = 4'h2,
        PLDC_F_67   = 4'h4,
        PLDC_F_100  = 4'h8
    } pldc_freq_t;

    function automatic logic [1:0] freq_code(input pldc_freq_t f);
        case (f)
            PLDC_F_33:  freq_code = 2'h1;
            PLDC_F_67:  freq_code = 2'h2;
            PLDC_F_100: freq_code = 2'h3;
            default:    freq_code = 2'h0;
        endcase
    endfunction : freq_code

endpackage : pldc_pkg

// ---- design/pldc_tile.sv ----
// One load tile: ROM with registered read, multiplier, shifter, eight pins
`timescale 1ns/10ps
module pldc_tile
    import pldc_pkg::*;
#(
    parameter logic [7:0] SEED = 8'h5A
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        active,
    input  wire logic        out_en,
    input  wire logic        tick,
    output logic [7:0]       pins_r,
    output logic [15:0]      product_r
);

    logic [7:0] lfsr_r;
    logic [7:0] rom_data_r;

    // Scrambled constant table, a different fill per tile
    function automatic logic [7:0] rom_word(input logic [3:0] a);
        logic [7:0] x;
        x = {a, ~a} ^ SEED;
        rom_word = {x[2:0], x[7:3]} ^ 8'h9D ^ {4'h0, a};
    endfunction : rom_word

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            lfsr_r <= LFSR_RESET ^ SEED;
        end else begin
            lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1); // [R10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rom_data_r <= 8'h00;
            product_r  <= 16'h0000;
        end else begin
            rom_data_r <= rom_word(lfsr_r[3:0]); // [R10]
            product_r  <= 16'(rom_data_r) * 16'(lfsr_r); // [R10]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pins_r <= 8'h00;
        end else if (!active || !out_en) begin
            pins_r <= 8'h00; // [R9]
        end else if (tick) begin
            pins_r <= ~pins_r; // [R8]
        end
    end

    shift_every_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R10]
        $past(rst_b) |-> lfsr_r != $past(lfsr_r))
        else $error("shift register held its value");

endmodule : pldc_tile

// ---- design/pldc_top.sv ----
// Power load demo controller: buttons, states, LEDs, bus slave, load tiles
`timescale 1ns/10ps

// Overview of operation
// R1 - Every operating rate is derived from the single reference clock input.
// R2 - The reset button returns the demo to stopped, lowest resource state, outputs off.
// R3 - Each frequency-step press moves to the next higher frequency state.
// R4 - The frequency state shows on two LEDs as 00 stop, 01 33, 10 67, 11 100 MHz; the code strobes at 1/3, 2/3 and 1 of the 10 MHz clock instead.
// R5 - Each utilisation-step press moves to the next higher resource state.
// R6 - The resource state shows on five LEDs as codes 0 to 19 for 5 to 100 percent.
// R7 - Each resource step adds eight driven pins, from 8 up to 160.
// R8 - Active pins toggle at the rate chosen by the frequency state.
// R9 - Pins only start toggling after an output-toggle press and stay idle otherwise.
// R10 - Each tile holds logic, a filled ROM, a multiplier and a shifter moving every cycle.
// R11 - While outputs are enabled an indicator LED is lit.
// R12 - A second output-toggle press disables the outputs and darkens the indicator.
// R13 - The design holds twenty tiles of eight pins each.
// R14 - Active-low buttons are synchronised, debounced and act once per press.
// R15 - Stepping past the top frequency or resource state wraps to the lowest.
module pldc_top
    import pldc_pkg::*;
#(
    parameter logic [19:0] DEBOUNCE_CYCLES = DEBOUNCE_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rst_b,
    input  wire logic                 push_button_zero_b,
    input  wire logic                 push_button_one_b,
    input  wire logic                 push_button_two_b,
    input  wire logic                 push_button_three_b,
    input  wire logic [3:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [3:0]           byteenable,
    input  wire logic [31:0]          writedata,
    output logic [31:0]               readdata,
    output logic                      waitrequest,
    output logic [1:0]                led_freq_r,
    output logic [4:0]                led_res_r,
    output logic                      led_out_en_r,
    output logic                      load_sink_r,
    output logic [PIN_COUNT-1:0]      load_pins
);

    logic [3:0]            btn_raw;
    logic [3:0]            sync1_r;
    logic [3:0]            sync2_r;
    logic [3:0]            stable_r;
    logic [3:0]            press_r;
    logic [19:0]           db_cnt_r [4];

    pldc_freq_t            freq_r;
    pldc_freq_t            freq_nxt;
    logic [4:0]            res_r;
    logic                  out_en_r;
    logic [1:0]            phase_r;
    logic [2:0]            phase_sum;
    logic                  tick_r;

    logic                  waitreq_r;
    logic [31:0]           rdata_r;
    logic                  bus_req;
    logic                  wr_acc;
    logic                  do_freq;
    logic                  do_res;
    logic                  do_tog;
    logic                  do_rst;

    logic [15:0]           product [TILE_COUNT];
    logic [TILE_COUNT-1:0] prod_par;

    assign btn_raw = {push_button_three_b, push_button_two_b,
                      push_button_one_b, push_button_zero_b};

    // Two-stage synchroniser for the pin inputs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            sync1_r <= 4'hF;
            sync2_r <= 4'hF;
        end else begin
            sync1_r <= btn_raw; // [R14]
            sync2_r <= sync1_r; // [R14]
        end
    end

    // Debounce: a level must differ from the accepted one for the full count
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            stable_r <= 4'hF;
            press_r  <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                db_cnt_r[i] <= 20'h00000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                press_r[i] <= 1'b0;
                if (sync2_r[i] == stable_r[i]) begin
                    db_cnt_r[i] <= 20'h00000;
                end else if (db_cnt_r[i] >= DEBOUNCE_CYCLES - 20'h00001) begin
                    db_cnt_r[i] <= 20'h00000;
                    stable_r[i] <= sync2_r[i]; // [R14]
                    press_r[i]  <= stable_r[i]; // [R14]
                end else begin
                    db_cnt_r[i] <= db_cnt_r[i] + 20'h00001;
                end
            end
        end
    end

    // Bus requests and button presses share one command path
    assign bus_req = read || write;
    assign wr_acc  = write && !waitreq_r && (address == ADDR_CTRL) && byteenable[0];
    assign do_rst  = press_r[BTN_RESET] || (wr_acc && writedata[CTRL_RST_BIT]);
    assign do_freq = press_r[BTN_FREQ] || (wr_acc && writedata[CTRL_FREQ_BIT]);
    assign do_res  = press_r[BTN_RES] || (wr_acc && writedata[CTRL_RES_BIT]);
    assign do_tog  = press_r[BTN_TOGGLE] || (wr_acc && writedata[CTRL_TOG_BIT]);

    always_comb begin
        case (freq_r)
            PLDC_F_STOP: freq_nxt = PLDC_F_33; // [R3]
            PLDC_F_33:   freq_nxt = PLDC_F_67; // [R3]
            PLDC_F_67:   freq_nxt = PLDC_F_100; // [R3]
            PLDC_F_100:  freq_nxt = PLDC_F_STOP; // [R15]
            default:     freq_nxt = PLDC_F_STOP;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || do_rst) begin
            freq_r <= PLDC_F_STOP; // [R2]
        end else if (do_freq) begin
            freq_r <= freq_nxt; // [R3]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || do_rst) begin
            res_r <= RES_RESET; // [R2]
        end else if (do_res) begin
            res_r <= (res_r == RES_LAST) ? RES_RESET : res_r + 5'h01; // [R5] [R15]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b || do_rst) begin
            out_en_r <= 1'b0; // [R2]
        end else if (do_tog) begin
            out_en_r <= !out_en_r; // [R9] [R12]
        end
    end

    // Rate strobe: adds the frequency code modulo three, giving 0, 1/3, 2/3, 1
    assign phase_sum = {1'b0, phase_r} + {1'b0, freq_code(freq_r)};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            phase_r <= 2'h0;
            tick_r  <= 1'b0;
        end else if (phase_sum >= {1'b0, PHASE_MOD}) begin
            phase_r <= 2'(phase_sum - {1'b0, PHASE_MOD}); // [R1] [R8]
            tick_r  <= 1'b1; // [R8]
        end else begin
            phase_r <= phase_sum[1:0];
            tick_r  <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            led_freq_r   <= 2'h0;
            led_res_r    <= RES_RESET;
            led_out_en_r <= 1'b0;
        end else begin
            led_freq_r   <= freq_code(freq_r); // [R4]
            led_res_r    <= res_r; // [R6]
            led_out_en_r <= out_en_r; // [R11] [R12]
        end
    end

    // Slave answers one cycle after a request appears, then rearms
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            waitreq_r <= 1'b1;
            rdata_r   <= 32'h00000000;
        end else begin
            waitreq_r <= !(bus_req && waitreq_r);
            if (read && waitreq_r) begin
                if (address == ADDR_STATUS) begin
                    rdata_r <= 32'h00000000;
                    rdata_r[STAT_FREQ_LSB +: 2] <= freq_code(freq_r);
                    rdata_r[STAT_RES_LSB +: 5]  <= res_r;
                    rdata_r[STAT_OUTEN_BIT]     <= out_en_r;
                end else begin
                    rdata_r <= 32'h00000000;
                end
            end
        end
    end

    assign readdata    = rdata_r;
    assign waitrequest = waitreq_r;

    // Twenty tiles; tile i drives pins while the resource code is at least i
    for (genvar g = 0; g < TILE_COUNT; g++) begin : g_tile
        pldc_tile #(
            .SEED      (8'(g * 37 + 11))
        ) u_tile (
            .ref_clk   (ref_clk),
            .rst_b     (rst_b),
            .active    (res_r >= 5'(g)), // [R7] [R13]
            .out_en    (out_en_r),
            .tick      (tick_r),
            .pins_r    (load_pins[g*TILE_PINS +: TILE_PINS]),
            .product_r (product[g])
        );
        assign prod_par[g] = ^product[g];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            load_sink_r <= 1'b0;
        end else begin
            load_sink_r <= ^prod_par; // [R10]
        end
    end

    freq_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R3]
        (do_freq && !do_rst && freq_r != PLDC_F_100)
        |=> freq_code(freq_r) == 2'($past(freq_code(freq_r)) + 2'h1))
        else $error("frequency step did not advance by one");

    freq_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
        (do_freq && !do_rst && freq_r == PLDC_F_100) |=> freq_r == PLDC_F_STOP)
        else $error("frequency did not wrap to stop");

    res_step_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R5]
        (do_res && !do_rst && res_r != RES_LAST) |=> res_r == $past(res_r) + 5'h01)
        else $error("resource step did not advance by one");

    res_wrap_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R15]
        (do_res && !do_rst && res_r == RES_LAST) |=> res_r == RES_RESET)
        else $error("resource state did not wrap");

    res_range_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
        res_r <= RES_LAST)
        else $error("resource code out of range");

    soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R2]
        do_rst |=> (freq_r == PLDC_F_STOP && res_r == RES_RESET && !out_en_r)
                   ##1 (led_freq_r == 2'h0 && led_res_r == RES_RESET && !led_out_en_r))
        else $error("reset press did not restore initial state");

    out_toggle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R12]
        (do_tog && !do_rst) |=> out_en_r != $past(out_en_r) ##1 led_out_en_r == out_en_r)
        else $error("output enable did not toggle");

    pins_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R9]
        (!out_en_r && $past(!out_en_r)) |-> load_pins == '0)
        else $error("pins active while outputs disabled");

    pin_count_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7]
        $stable(res_r) && $past(rst_b)
        |-> (load_pins >> (TILE_PINS * (32'(res_r) + 1))) == '0)
        else $error("pins above the resource count are driven");

    tick_full_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        (freq_r == PLDC_F_100) [*2] |-> tick_r)
        else $error("full rate strobe missed a cycle");

    tick_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        (freq_r == PLDC_F_STOP) [*2] |-> !tick_r)
        else $error("strobe active while stopped");

    press_once_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
        press_r[BTN_FREQ] |=> !press_r[BTN_FREQ])
        else $error("button press lasted more than one cycle");

    bus_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (bus_req && waitreq_r) |=> !waitreq_r ##1 waitreq_r)
        else $error("bus answer not one cycle after request");

    // Indicator, strobe and pin checks
    led_track_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R4] [R6] [R11]
        $past(rst_b) |-> led_freq_r == $past(freq_code(freq_r))
            && led_res_r == $past(res_r) && led_out_en_r == $past(out_en_r))
        else $error("indicator LEDs do not follow the states");

    tick_third_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        (freq_r == PLDC_F_33) [*3] |-> !(tick_r && $past(tick_r)))
        else $error("low rate strobe fired twice in a row");

    tick_two_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        (freq_r == PLDC_F_67) [*3] |-> (tick_r || $past(tick_r)))
        else $error("middle rate strobe missed two cycles");

    pins_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R8]
        (tick_r && out_en_r)
        |=> load_pins[TILE_PINS-1:0] == ~$past(load_pins[TILE_PINS-1:0]))
        else $error("first tile pins did not toggle on the strobe");

    pins_last_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R7] [R13]
        (tick_r && out_en_r && res_r == RES_LAST)
        |=> load_pins[PIN_COUNT-1 -: TILE_PINS] == ~$past(load_pins[PIN_COUNT-1 -: TILE_PINS]))
        else $error("last tile pins did not toggle at full resources");

    // Button, bus and state hold checks
    press_level_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
        (press_r & stable_r) == 4'h0)
        else $error("press pulse without a pressed level");

    db_limit_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R14]
        db_cnt_r[BTN_FREQ] < DEBOUNCE_CYCLES)
        else $error("debounce counter ran past its limit");

    res_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R5]
        (!do_res && !do_rst) |=> $stable(res_r))
        else $error("resource state moved without a step");

    bus_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b) // [R6]
        (read && waitreq_r && address == ADDR_STATUS)
        |=> readdata[7:0] == {$past(out_en_r), $past(res_r), $past(freq_code(freq_r))})
        else $error("status read does not match the states");

    write_lane_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (write && !waitreq_r && !byteenable[0] && press_r == 4'h0)
        |=> $stable(freq_r) && $stable(res_r) && $stable(out_en_r))
        else $error("write without byte lane changed a state");

    waitreq_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !bus_req |=> waitreq_r)
        else $error("wait request low without a request");

    // Scenario coverage
    res_wrap_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        do_res && res_r == RES_LAST);

    freq_top_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        freq_r == PLDC_F_100 && out_en_r && load_pins != '0);

    toggle_off_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        out_en_r ##1 !out_en_r);

    freq_wrap_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        do_freq && freq_r == PLDC_F_100);

    soft_reset_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        do_rst && out_en_r);

endmodule : pldc_top
